// *** inc/cpr_params.svh ***
// Register offsets, field positions and reset values of the channel power and offset bank
`ifndef CPR_PARAMS_SVH
`define CPR_PARAMS_SVH

// Register addresses of the bank
`define CPR_ADDR_PWR_INV_CTRL   8'h18
`define CPR_ADDR_CH5_GAIN_OFS   8'h19
`define CPR_ADDR_CH5_OFS_COPY   8'h1A

// Field positions inside the power and invert register
`define CPR_DIG_SLEEP_MSB       15
`define CPR_DIG_SLEEP_LSB       12
`define CPR_LINE_SLEEP_MSB      11
`define CPR_LINE_SLEEP_LSB      8
`define CPR_ANA_SLEEP_MSB       7
`define CPR_ANA_SLEEP_LSB       4
`define CPR_FLIP_MSB            3
`define CPR_FLIP_LSB            0

// Field positions inside the channel 5 registers
`define CPR_GAIN_MSB            15
`define CPR_GAIN_LSB            11
`define CPR_OFS_MSB             9
`define CPR_OFS_LSB             0

// Reset values
`define CPR_RST_PWR_INV_CTRL    16'h0000
`define CPR_RST_CH5_GAIN_OFS    16'h0000
`define CPR_RST_CH5_OFS_COPY    16'h0000
`define CPR_RST_SAMPLE          14'h0000

`endif

// *** inc/cpr_pkg.sv ***
// Types shared by the channel power and offset bank
package cpr_pkg;

	// Width of register words and samples
	typedef logic [15:0] cpr_word_t;
	typedef logic [13:0] cpr_sample_t;
	typedef logic [7:0]  cpr_addr_t;

	// Layout of the power and invert register, index 0 is channel or line 1
	typedef struct packed {
		logic [3:0] dig_sleep;   // Digital block sleep, ch4..ch1
		logic [3:0] line_sleep;  // Serial line sleep, 4..1
		logic [3:0] ana_sleep;   // Analog block sleep, ch4..ch1
		logic [3:0] flip;        // Output polarity flip, 4..1
	} cpr_pwr_inv_s;

	// Controls handed to one serial output line
	typedef struct packed {
		logic sleep;       // Line powered down
		logic flip;        // Invert normal sample data
		logic pattern_on;  // Test pattern drives the line
	} cpr_line_ctrl_s;

endpackage : cpr_pkg

// *** design/cpr_line_out.sv ***
// One serial output line: polarity flip, test pattern select and sleep
`timescale 1ns/1ps
`include "cpr_params.svh"

module cpr_line_out
	import cpr_pkg::*;
(
	input  wire logic           i_clk,      // System clock
	input  wire logic           i_reset_n,  // Synchronous reset, active low
	input  wire cpr_line_ctrl_s i_ctrl,     // Line controls
	input  wire cpr_sample_t    i_sample,   // Normal sample data
	input  wire cpr_sample_t    i_pattern,  // Test pattern data
	output logic                o_sleep,    // Line asleep
	output cpr_sample_t         o_data      // Data toward the serializer
);

	cpr_sample_t data_reg;   // Registered line data
	cpr_sample_t data_next;  // Next line data
	logic        sleep_reg;  // Registered sleep state
	logic        sleep_next; // Next sleep state

	// Choose what the line carries
	always_comb begin
		sleep_next = i_ctrl.sleep;
		if (i_ctrl.sleep) begin
			// A sleeping line holds zero so no stale data toggles the pins
			data_next = `CPR_RST_SAMPLE;
		end else if (i_ctrl.pattern_on) begin
			data_next = i_pattern;
		end else if (i_ctrl.flip) begin
			data_next = ~i_sample;
		end else begin
			data_next = i_sample;
		end
	end

	// Register the line state
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			data_reg  <= `CPR_RST_SAMPLE;
			sleep_reg <= 1'b0;
		end else begin
			data_reg  <= data_next;
			sleep_reg <= sleep_next;
		end
	end

	assign o_data  = data_reg;
	assign o_sleep = sleep_reg;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	property p_flip_inverts;
		!i_ctrl.sleep && !i_ctrl.pattern_on && i_ctrl.flip |=> o_data == ~$past(i_sample);
	endproperty
	a_flip_inverts: assert property (p_flip_inverts)
		else $error("flipped line does not carry inverted sample");

	property p_pattern_untouched;
		!i_ctrl.sleep && i_ctrl.pattern_on |=> o_data == $past(i_pattern);
	endproperty
	a_pattern_untouched: assert property (p_pattern_untouched)
		else $error("test pattern altered on its way out");

	property p_sleep_quiet;
		i_ctrl.sleep |=> o_sleep && o_data == `CPR_RST_SAMPLE;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet)
		else $error("sleeping line still carries data");

	c_flip_pattern: cover property (i_ctrl.flip && i_ctrl.pattern_on && !i_ctrl.sleep);

endmodule : cpr_line_out

// *** design/cpr_regs.sv ***
// Power, polarity and channel 5 gain and offset register bank with its data paths
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "cpr_params.svh"

module cpr_regs
	import cpr_pkg::*;
(
	input  wire logic         i_clk,                    // System clock, 10 MHz
	input  wire logic         i_reset_n,                // Synchronous reset, active low
	input  wire cpr_addr_t    i_addr,                   // Register address
	input  wire cpr_word_t    i_wdata,                  // Write data
	input  wire logic         i_wr,                     // Write strobe, one cycle
	input  wire logic         i_rd,                     // Read strobe, one cycle
	input  wire logic         i_gain_apply_enable,      // Digital gain enable
	input  wire logic         i_offset_apply_enable,    // Digital offset enable
	input  wire logic [3:0]   i_pattern_on,             // Test pattern active per line
	input  wire cpr_sample_t  i_pattern [4],            // Test pattern data per line
	input  wire cpr_sample_t  i_sample [4],             // Normal sample data per line
	input  wire cpr_sample_t  i_ch5_sample,             // Channel 5 sample, two's complement
	output cpr_word_t         o_rdata,                  // Read data, cycle after read strobe
	output logic [3:0]        o_digital_block_sleep,    // Digital block sleep, ch4..ch1
	output logic [3:0]        o_analog_block_sleep,     // Analog block sleep, ch4..ch1
	output logic [3:0]        o_serial_line_sleep,      // Serial line sleep, 4..1
	output cpr_sample_t       o_line_data [4],          // Data per serial line
	output logic [4:0]        o_fifth_channel_gain_code,// Gain code in force, 0 when off
	output cpr_sample_t       o_ch5_data,               // Channel 5 sample with offset
	output logic              o_offset_copy_mismatch    // Offset copies disagree
);

	// Register storage
	cpr_pwr_inv_s pwr_reg;       // Power and invert controls
	cpr_pwr_inv_s pwr_next;
	cpr_word_t    gofs_reg;      // Channel 5 gain and offset
	cpr_word_t    gofs_next;
	cpr_word_t    ocopy_reg;     // Channel 5 offset copy
	cpr_word_t    ocopy_next;
	cpr_word_t    rdata_reg;     // Read data
	cpr_word_t    rdata_next;

	// Register write and read decode
	always_comb begin
		pwr_next   = pwr_reg;
		gofs_next  = gofs_reg;
		ocopy_next = ocopy_reg;
		rdata_next = 16'h0000;
		if (i_wr) begin
			unique case (i_addr)
				`CPR_ADDR_PWR_INV_CTRL: pwr_next   = cpr_pwr_inv_s'(i_wdata);
				`CPR_ADDR_CH5_GAIN_OFS: gofs_next  = i_wdata;
				`CPR_ADDR_CH5_OFS_COPY: ocopy_next = i_wdata;
				// Unmapped writes are dropped
				default:                pwr_next   = pwr_reg;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				`CPR_ADDR_PWR_INV_CTRL: rdata_next = cpr_word_t'(pwr_reg);
				`CPR_ADDR_CH5_GAIN_OFS: rdata_next = gofs_reg;
				`CPR_ADDR_CH5_OFS_COPY: rdata_next = ocopy_reg;
				// Unmapped reads return zero
				default:                rdata_next = 16'h0000;
			endcase
		end
	end

	// Register the bank
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			pwr_reg   <= cpr_pwr_inv_s'(`CPR_RST_PWR_INV_CTRL);
			gofs_reg  <= `CPR_RST_CH5_GAIN_OFS;
			ocopy_reg <= `CPR_RST_CH5_OFS_COPY;
			rdata_reg <= 16'h0000;
		end else begin
			pwr_reg   <= pwr_next;
			gofs_reg  <= gofs_next;
			ocopy_reg <= ocopy_next;
			rdata_reg <= rdata_next;
		end
	end

	assign o_rdata               = rdata_reg;
	assign o_digital_block_sleep = pwr_reg.dig_sleep;
	assign o_analog_block_sleep  = pwr_reg.ana_sleep;

	// One output path per serial line
	for (genvar g = 0; g < 4; g++) begin : g_line
		cpr_line_ctrl_s ctrl;  // Controls for this line
		assign ctrl = '{sleep: pwr_reg.line_sleep[g], flip: pwr_reg.flip[g],
			pattern_on: i_pattern_on[g]};
		cpr_line_out u_line (
			.i_clk     (i_clk),
			.i_reset_n (i_reset_n),
			.i_ctrl    (ctrl),
			.i_sample  (i_sample[g]),
			.i_pattern (i_pattern[g]),
			.o_sleep   (o_serial_line_sleep[g]),
			.o_data    (o_line_data[g])
		);
	end

	// Channel 5 path state
	logic [4:0]  gain_reg;      // Gain code in force
	logic [4:0]  gain_next;
	cpr_sample_t ch5_reg;       // Offset-corrected sample
	cpr_sample_t ch5_next;
	logic        mism_reg;      // Copies disagree
	logic        mism_next;
	logic [9:0]  ofs;           // Stored offset
	logic [14:0] sum;           // Widened sum for saturation

	assign ofs = gofs_reg[`CPR_OFS_MSB:`CPR_OFS_LSB];

	// Gain code, offset add and copy check
	always_comb begin
		// gain code only when enabled; zero code is 0 dB
		gain_next = i_gain_apply_enable ? gofs_reg[`CPR_GAIN_MSB:`CPR_GAIN_LSB] : 5'h00;
		// offset LSB equals sample LSB, sign extended
		sum = {i_ch5_sample[13], i_ch5_sample} + {{5{ofs[9]}}, ofs};
		if (!i_offset_apply_enable) begin
			ch5_next = i_ch5_sample;
		end else if (sum[14] != sum[13]) begin
			// Clamp instead of wrapping so a large offset cannot flip the sign
			ch5_next = sum[14] ? 14'h2000 : 14'h1FFF;
		end else begin
			ch5_next = sum[13:0];
		end
		// host keeps both copies equal; flag when it does not
		mism_next = ocopy_reg[`CPR_OFS_MSB:`CPR_OFS_LSB] != ofs;
	end

	// Register the channel 5 path
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			gain_reg <= 5'h00;
			ch5_reg  <= `CPR_RST_SAMPLE;
			mism_reg <= 1'b0;
		end else begin
			gain_reg <= gain_next;
			ch5_reg  <= ch5_next;
			mism_reg <= mism_next;
		end
	end

	assign o_fifth_channel_gain_code = gain_reg;
	assign o_ch5_data                = ch5_reg;
	assign o_offset_copy_mismatch    = mism_reg;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	property p_dig_sleep_write;
		i_wr && i_addr == `CPR_ADDR_PWR_INV_CTRL |=>
			o_digital_block_sleep == $past(i_wdata[`CPR_DIG_SLEEP_MSB:`CPR_DIG_SLEEP_LSB]);
	endproperty
	a_dig_sleep_write: assert property (p_dig_sleep_write)
		else $error("digital sleep bits not taken from write");

	property p_line_sleep_write;
		i_wr && i_addr == `CPR_ADDR_PWR_INV_CTRL |=>
			##1 o_serial_line_sleep == $past(i_wdata[`CPR_LINE_SLEEP_MSB:`CPR_LINE_SLEEP_LSB], 2);
	endproperty
	a_line_sleep_write: assert property (p_line_sleep_write)
		else $error("line sleep does not follow write");

	property p_ana_sleep_write;
		i_wr && i_addr == `CPR_ADDR_PWR_INV_CTRL |=>
			o_analog_block_sleep == $past(i_wdata[`CPR_ANA_SLEEP_MSB:`CPR_ANA_SLEEP_LSB]);
	endproperty
	a_ana_sleep_write: assert property (p_ana_sleep_write)
		else $error("analog sleep bits not taken from write");

	property p_flip_readback;
		i_wr && i_addr == `CPR_ADDR_PWR_INV_CTRL ##1 i_rd && i_addr == `CPR_ADDR_PWR_INV_CTRL
			|=> o_rdata[3:0] == $past(i_wdata[3:0], 2);
	endproperty
	a_flip_readback: assert property (p_flip_readback)
		else $error("flip bits read back wrong");

	property p_reset_clear;
		$rose(i_reset_n) |-> o_digital_block_sleep == 4'h0 && o_analog_block_sleep == 4'h0
			&& o_serial_line_sleep == 4'h0 && o_rdata == 16'h0000;
	endproperty
	a_reset_clear: assert property (disable iff (1'b0) p_reset_clear)
		else $error("controls not cleared by reset");

	property p_gain_enabled;
		i_gain_apply_enable |=>
			o_fifth_channel_gain_code == $past(gofs_reg[`CPR_GAIN_MSB:`CPR_GAIN_LSB]);
	endproperty
	a_gain_enabled: assert property (p_gain_enabled)
		else $error("gain code in force differs from stored code");

	property p_offset_small;
		i_offset_apply_enable && i_ch5_sample == 14'h0000 |=>
			o_ch5_data == {{4{$past(ofs[9])}}, $past(ofs)};
	endproperty
	a_offset_small: assert property (p_offset_small)
		else $error("offset not added at sample LSB");

	property p_bypass;
		!i_offset_apply_enable && !i_gain_apply_enable |=>
			o_ch5_data == $past(i_ch5_sample) && o_fifth_channel_gain_code == 5'h00;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("disabled gain or offset altered the sample");

	property p_read_one_cycle;
		!i_rd |=> o_rdata == 16'h0000;
	endproperty
	a_read_one_cycle: assert property (p_read_one_cycle)
		else $error("read data present without a read");

	c_write_ctrl:   cover property (i_wr && i_addr == `CPR_ADDR_PWR_INV_CTRL ##1 i_rd);
	c_offset_on:    cover property (i_offset_apply_enable && ofs != 10'h000);
	c_copy_differ:  cover property (o_offset_copy_mismatch);
	c_saturate:     cover property (i_offset_apply_enable && sum[14] != sum[13]);

endmodule : cpr_regs

// *** verification/cpr_regs_test.sv ***
// Self-checking testbench for the channel power, polarity and channel 5 offset bank
`timescale 1ns/1ps
`include "cpr_params.svh"

module cpr_regs_test
	import cpr_pkg::*;
;
	logic        i_clk;                 // 10 MHz clock
	logic        i_reset_n;             // Synchronous reset, active low
	cpr_addr_t   i_addr;                // Register address
	cpr_word_t   i_wdata;               // Write data
	logic        i_wr;                  // Write strobe
	logic        i_rd;                  // Read strobe
	logic        i_gain_apply_enable;   // Digital gain enable
	logic        i_offset_apply_enable; // Digital offset enable
	logic [3:0]  i_pattern_on;          // Test pattern select per line
	cpr_sample_t i_pattern [4];         // Test pattern data
	cpr_sample_t i_sample [4];          // Normal sample data
	cpr_sample_t i_ch5_sample;          // Channel 5 sample
	cpr_word_t   o_rdata;               // Read data
	logic [3:0]  o_digital_block_sleep; // Digital sleep
	logic [3:0]  o_analog_block_sleep;  // Analog sleep
	logic [3:0]  o_serial_line_sleep;   // Line sleep
	cpr_sample_t o_line_data [4];       // Line data
	logic [4:0]  o_fifth_channel_gain_code; // Gain code in force
	cpr_sample_t o_ch5_data;            // Channel 5 result
	logic        o_offset_copy_mismatch; // Offset copies disagree
	int          bad_count;             // Mismatches seen
	int          compares;              // Comparisons made

	// Device under test
	cpr_regs cpr_regs_inst (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .i_gain_apply_enable(i_gain_apply_enable),
		.i_offset_apply_enable(i_offset_apply_enable), .i_pattern_on(i_pattern_on),
		.i_pattern(i_pattern), .i_sample(i_sample), .i_ch5_sample(i_ch5_sample),
		.o_rdata(o_rdata), .o_digital_block_sleep(o_digital_block_sleep),
		.o_analog_block_sleep(o_analog_block_sleep), .o_serial_line_sleep(o_serial_line_sleep),
		.o_line_data(o_line_data), .o_fifth_channel_gain_code(o_fifth_channel_gain_code),
		.o_ch5_data(o_ch5_data), .o_offset_copy_mismatch(o_offset_copy_mismatch)
	);

	// Free-running clock, 100 ns period
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// One comparison; case equality so an unknown never matches
	task automatic chk(input cpr_word_t got, input cpr_word_t exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Verdict and end of run
	task automatic results();
		if (bad_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	// Single-cycle write; the slave never stalls
	task automatic wr(input cpr_addr_t a, input cpr_word_t d);
		@(posedge i_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr    <= 1'b0;
	endtask : wr

	// Read; data stands only in the cycle after the strobe
	task automatic rd(input cpr_addr_t a, input cpr_word_t e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd   <= 1'b0;
		#1 chk(o_rdata, e);
	endtask : rd

	// Write then read the same register with no gap; the read must see the new value
	task automatic wr_rd(input cpr_addr_t a, input cpr_word_t d, input cpr_word_t e);
		@(posedge i_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr    <= 1'b0;
		i_rd    <= 1'b1;
		@(posedge i_clk);
		i_rd    <= 1'b0;
		#1 chk(o_rdata, e);
	endtask : wr_rd

	// Two edges cover the longest path, a register write reaching line data
	task automatic settle();
		repeat (2) @(posedge i_clk);
		#1;
	endtask : settle

	// Expected line data: sleep wins, then pattern, then polarity flip
	function automatic cpr_sample_t exp_line(input int g, input cpr_word_t w);
		if (w[8+g]) return 14'h0000;
		if (i_pattern_on[g]) return i_pattern[g];
		return w[g] ? ~i_sample[g] : i_sample[g];
	endfunction : exp_line

	// Reset values of all three registers and the sleep outputs
	task automatic t_reset();
		chk({o_digital_block_sleep, o_serial_line_sleep, o_analog_block_sleep, 4'h0}, 16'h0000);
		rd(`CPR_ADDR_PWR_INV_CTRL, `CPR_RST_PWR_INV_CTRL);
		rd(`CPR_ADDR_CH5_GAIN_OFS, `CPR_RST_CH5_GAIN_OFS);
		rd(`CPR_ADDR_CH5_OFS_COPY, `CPR_RST_CH5_OFS_COPY);
	endtask : t_reset

	// Walking one through the power register catches swapped or shifted fields
	task automatic t_power();
		cpr_word_t w;
		for (int i = 0; i < 16; i++) begin
			w = 16'h0001 << i;
			wr(`CPR_ADDR_PWR_INV_CTRL, w);
			settle();
			chk({o_digital_block_sleep, o_serial_line_sleep, o_analog_block_sleep, 4'h0},
				{w[15:4], 4'h0});
			for (int g = 0; g < 4; g++) begin
				chk({2'h0, o_line_data[g]}, {2'h0, exp_line(g, w)});
			end
			rd(`CPR_ADDR_PWR_INV_CTRL, w);
		end
	endtask : t_power

	// All lines flipped, lines 1 and 3 carry a pattern that must pass untouched
	task automatic t_pattern();
		@(posedge i_clk);
		i_pattern_on <= 4'h5;
		wr_rd(`CPR_ADDR_PWR_INV_CTRL, 16'h000F, 16'h000F);
		settle();
		for (int g = 0; g < 4; g++) begin
			chk({2'h0, o_line_data[g]}, {2'h0, exp_line(g, 16'h000F)});
		end
	endtask : t_pattern

	// Gain code, offset with both saturation ends, enables, copy check, unmapped access
	task automatic t_ch5();
		wr(`CPR_ADDR_CH5_GAIN_OFS, 16'hABFF);
		@(posedge i_clk);
		i_ch5_sample <= 14'h0100;
		settle();
		chk({11'h000, o_fifth_channel_gain_code}, 16'h0000);
		chk({2'h0, o_ch5_data}, 16'h0100);
		chk({15'h0000, o_offset_copy_mismatch}, 16'h0001);
		@(posedge i_clk);
		i_gain_apply_enable   <= 1'b1;
		i_offset_apply_enable <= 1'b1;
		settle();
		chk({11'h000, o_fifth_channel_gain_code}, 16'h0015);
		chk({2'h0, o_ch5_data}, 16'h00FF);
		@(posedge i_clk);
		i_ch5_sample <= 14'h2000;
		settle();
		chk({2'h0, o_ch5_data}, 16'h2000);
		wr(`CPR_ADDR_CH5_GAIN_OFS, 16'h01FF);
		@(posedge i_clk);
		i_ch5_sample <= 14'h1F00;
		settle();
		chk({2'h0, o_ch5_data}, 16'h1FFF);
		chk({11'h000, o_fifth_channel_gain_code}, 16'h0000);
		wr(`CPR_ADDR_CH5_OFS_COPY, 16'h01FF);
		settle();
		chk({15'h0000, o_offset_copy_mismatch}, 16'h0000);
		rd(`CPR_ADDR_CH5_OFS_COPY, 16'h01FF);
		// Zero sample shows the bare sign-extended offset
		@(posedge i_clk);
		i_ch5_sample <= 14'h0000;
		settle();
		chk({2'h0, o_ch5_data}, 16'h01FF);
		// Unmapped address: write ignored, read gives zero
		wr(8'h1B, 16'hFFFF);
		rd(8'h1B, 16'h0000);
		rd(`CPR_ADDR_PWR_INV_CTRL, 16'h000F);
	endtask : t_ch5

	// Reset in mid-run must clear registers that hold non-zero values
	task automatic t_midreset();
		wr(`CPR_ADDR_PWR_INV_CTRL, 16'hFFFF);
		settle();
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_reset_n <= 1'b1;
		settle();
		t_reset();
	endtask : t_midreset

	// Main sequence
	initial begin
		bad_count             = 0;
		compares              = 0;
		i_reset_n             = 1'b0;
		i_addr                = 8'h00;
		i_wdata               = 16'h0000;
		i_wr                  = 1'b0;
		i_rd                  = 1'b0;
		i_gain_apply_enable   = 1'b0;
		i_offset_apply_enable = 1'b0;
		i_pattern_on          = 4'h0;
		i_ch5_sample          = 14'h0000;
		for (int g = 0; g < 4; g++) begin
			i_sample[g]  = 14'h1A50 ^ 14'(g);
			i_pattern[g] = 14'h0C30 + 14'(g);
		end
		repeat (3) @(posedge i_clk);
		i_reset_n <= 1'b1;
		settle();
		t_reset();
		t_power();
		t_pattern();
		t_ch5();
		t_midreset();
		results();
	end

endmodule : cpr_regs_test
